/* File: hdl/phase_manager.sv */
// Contract
// R1: peak trip ends pulse, latches controller off
// R2: only configured channels sense and switch
// R3: mode at rail disables all light-load features
// R4: dropping enabled only when mode below threshold
// R5: four-phase drops at 75 and 50 percent
// R6: dropped phase shows mid level when tri-select
// R7: driver holds both switches off at mid
// R8: dropped phase duty ramps down over 15 cycles
// R9: above threshold plus hysteresis add one phase
// R10: while dropped, two-thirds trip restores all phases
// R11: wait 1.5 ms before dropping again
// R12: limit hit while adding blanks latch-off 200us
// R13: diode emulation mids output after zero current
// R14: diode emulation needs tri-select and two phases
// R15: never below two phases, go emulation instead
// R16: falling load in emulation starts pulse skipping
// R17: tri-select low means two-level outputs only
// R18: decisions taken once per switching cycle
`timescale 1ns/10ps
`default_nettype none
`include "phase_mgr_defs.svh"

module phase_manager
    import phase_mgr_pkg::*;
#(
    parameter int RESTORE_CYC = `RESTORE_DELAY_CYC,
    parameter int BLANK_CYC   = `BLANK_TIME_CYC
)
(
    // clock and reset
    input  wire logic                 sys_clk,
    input  wire logic                 rst,
    // configuration pins
    input  wire logic                 third_phase_strap,
    input  wire logic                 fourth_phase_strap,
    input  wire logic                 tri_select,
    input  wire logic                 mode_at_rail,
    input  wire logic                 mode_below_disable,
    // total current comparators, already scaled against the mode level
    input  wire logic                 total_below_75,
    input  wire logic                 total_below_50,
    input  wire logic                 total_above_hyst,
    input  wire logic                 light_load_low,
    input  wire logic                 deep_light_load,
    // per-channel current comparators
    input  wire logic [3:0]           peak_trip,
    input  wire logic [3:0]           two_thirds_trip,
    input  wire logic [3:0]           zero_current,
    // control loop
    input  wire logic [`DUTY_W-1:0]   steady_duty,
    input  wire logic [`DUTY_W-1:0]   ramp,
    input  wire logic                 cycle_start,
    // outputs
    output logic [1:0]                phase_out [4],
    output logic [3:0]                channel_active,
    output logic [2:0]                phase_count,
    output logic                      latched_off,
    output light_mode_t               light_mode
);

    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    localparam int NS = 22;
    logic [NS-1:0] sync_a;
    logic [NS-1:0] sync_b;
    logic [NS-1:0] raw_in;

    assign raw_in = {third_phase_strap, fourth_phase_strap, tri_select, mode_at_rail,
                     mode_below_disable, total_below_75, total_below_50, total_above_hyst,
                     light_load_low, deep_light_load, peak_trip, two_thirds_trip, zero_current};

    // analog comparators are asynchronous to the switching clock
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            sync_a <= '0;
            sync_b <= '0;
        end
        else
        begin
            sync_a <= raw_in;
            sync_b <= sync_a;
        end
    end

    logic       s_str3, s_str4, s_tri, s_rail, s_below, s_b75, s_b50, s_hyst, s_low, s_deep;
    logic [3:0] s_peak, s_two3, s_zero;

    assign {s_str3, s_str4, s_tri, s_rail, s_below, s_b75, s_b50, s_hyst, s_low, s_deep,
            s_peak, s_two3, s_zero} = sync_b;

    // ------------------------------------------------------------
    // configuration
    // ------------------------------------------------------------
    logic [2:0] max_phases;
    logic [3:0] cfg_mask;
    logic       ll_enable;

    // straps pick 2, 3 or 4 phases
    assign max_phases = s_str4 ? 3'h4 : (s_str3 ? 3'h3 : 3'h2);           // R2
    assign cfg_mask   = s_str4 ? 4'hF : (s_str3 ? 4'h7 : 4'h3);           // R2
    assign ll_enable  = s_below && !s_rail;                               // R3 R4

    function automatic logic [3:0] mask_of(input logic [2:0] n);
        mask_of = (n == 3'h4) ? 4'hF : ((n == 3'h3) ? 4'h7 : 4'h3);
    endfunction

    // ------------------------------------------------------------
    // protection and timers
    // ------------------------------------------------------------
    logic [17:0] restore_cnt;
    logic [15:0] blank_cnt;
    logic        adding;
    logic        any_peak;
    logic        any_two3;

    assign any_peak = |(s_peak & channel_active);                         // R2
    assign any_two3 = |(s_two3 & channel_active);

    // a trip outside blanking latches off until reset, except while adding with light load enabled
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            latched_off <= 1'b0;
        else if (any_peak && blank_cnt == '0 && !(adding && ll_enable))
            latched_off <= 1'b1;                                          // R1
    end

    // blanking armed by a limit hit while phases are being added
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            blank_cnt <= '0;
        else if (adding && any_peak && blank_cnt == '0)
            blank_cnt <= 16'(BLANK_CYC);                                  // R12
        else if (blank_cnt != '0)
            blank_cnt <= blank_cnt - 16'h0001;
    end

    // ------------------------------------------------------------
    // phase count decision
    // ------------------------------------------------------------
    logic [2:0]         target;
    logic [2:0]         next_count;
    logic [3:0]         ramp_left;
    logic [3:0]         ramp_mask;
    logic [`DUTY_W-1:0] ramp_duty;

    // thresholds only apply where that many phases exist
    always_comb
    begin
        target = max_phases;
        if (max_phases == 3'h4 && s_b75)
            target = 3'h3;                                                // R5
        if (s_b50)
            target = 3'h2;                                                // R5 R15
    end

    always_comb
    begin
        next_count = phase_count;
        if (!ll_enable || phase_count > max_phases)
            next_count = max_phases;
        else if (phase_count < max_phases && any_two3)
            next_count = max_phases;                                      // R10
        else if (restore_cnt != '0)
            next_count = phase_count;                                     // R11
        else if (s_hyst && phase_count < max_phases)
            next_count = phase_count + 3'h1;                              // R9
        else if (!s_hyst && target < phase_count && ramp_left == '0 && ramp_mask != '0)
            next_count = phase_count - 3'h1;                              // R5 R15
    end

    // all-phase restore holds off dropping for a fixed delay
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            restore_cnt <= '0;
        else if (ll_enable && phase_count < max_phases && any_two3)
            restore_cnt <= 18'(RESTORE_CYC);                              // R11
        else if (restore_cnt != '0)
            restore_cnt <= restore_cnt - 18'h00001;
    end

    // count moves only at a switching-cycle boundary
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            phase_count <= 3'h2;
        else if (cycle_start)
            phase_count <= next_count;                                    // R18
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            adding <= 1'b0;
        else if (cycle_start)
            adding <= next_count > phase_count;
    end

    // ------------------------------------------------------------
    // gradual duty ramp-down of the phase being dropped
    // ------------------------------------------------------------
    // a drop first runs 15 shrinking cycles, then the count steps down
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            ramp_left <= '0;
            ramp_mask <= '0;
        end
        else if (cycle_start)
        begin
            if (ll_enable && target < phase_count && !s_hyst && restore_cnt == '0
                && ramp_left == '0 && ramp_mask == '0)
            begin
                ramp_left <= 4'(`RAMP_CYCLES);                            // R8
                ramp_mask <= mask_of(phase_count) & ~mask_of(phase_count - 3'h1);
            end
            else if (ramp_left != '0)
                ramp_left <= ramp_left - 4'h1;                            // R8
            else
                ramp_mask <= '0;
        end
        else if (next_count > phase_count)
        begin
            // an add restores full duty at once, so no stale ramp may linger
            ramp_left <= '0;
            ramp_mask <= '0;
        end
    end

    // duty scaled linearly by remaining ramp cycles
    assign ramp_duty = `DUTY_W'((16'(steady_duty) * 16'(ramp_left)) / 16'(`RAMP_CYCLES));

    // ------------------------------------------------------------
    // light-load mode
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            light_mode <= LL_NORMAL;
        else if (cycle_start)
        begin
            if (!ll_enable || !s_tri || phase_count != 3'h2 || !s_low)
                light_mode <= LL_NORMAL;                                  // R14 R3
            else if (s_deep)
                light_mode <= LL_PULSE_SKIP;                              // R16
            else
                light_mode <= LL_DIODE_EMU;                               // R15
        end
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            channel_active <= '0;
        else
            channel_active <= cfg_mask & (mask_of(phase_count) | ramp_mask);  // R2
    end

    // ------------------------------------------------------------
    // phase outputs
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < 4; g++)
        begin : gen_ph
            phase_pwm u_pwm
            (
                .sys_clk    (sys_clk),
                .rst        (rst),
                .ramp       (ramp),
                .duty       (ramp_mask[g] ? ramp_duty : steady_duty),
                .enable     (channel_active[g] && !latched_off),
                .tri_sel    (s_tri),                                      // R17
                .diode_emu  (light_mode == LL_DIODE_EMU),
                .skip       (light_mode == LL_PULSE_SKIP),
                .zero_cross (s_zero[g]),
                .kill       (s_peak[g] || latched_off),                   // R1
                .level      (phase_out[g])
            );
        end
    endgenerate

endmodule

`default_nettype wire

/* File: hdl/phase_pwm.sv */
`timescale 1ns/10ps
`default_nettype none
`include "phase_mgr_defs.svh"

// one phase: duty comparator against a ramp, with output shaping
module phase_pwm
    import phase_mgr_pkg::*;
(
    // clock and reset
    input  wire logic                 sys_clk,
    input  wire logic                 rst,
    // timing
    input  wire logic [`DUTY_W-1:0]   ramp,
    input  wire logic [`DUTY_W-1:0]   duty,
    // control
    input  wire logic                 enable,
    input  wire logic                 tri_sel,
    input  wire logic                 diode_emu,
    input  wire logic                 skip,
    input  wire logic                 zero_cross,
    input  wire logic                 kill,
    // pin
    output logic [1:0]                level
);

    logic on_now;

    // on while ramp is below duty; a kill ends the pulse at once
    assign on_now = enable && !kill && !skip && (ramp < duty);

    // idle level is mid only when tri-level is allowed
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            level <= PH_LOW;
        else if (!enable)
            level <= tri_sel ? PH_MID : PH_LOW;   // R6 R17
        else if (on_now)
            level <= PH_HIGH;
        else if (tri_sel && (diode_emu || skip) && zero_cross)
            level <= PH_MID;                      // R13
        else
            level <= PH_LOW;
    end

endmodule

`default_nettype wire

/* File: shared/phase_mgr_defs.svh */
`ifndef PHASE_MGR_DEFS_SVH
`define PHASE_MGR_DEFS_SVH

// clock rate and derived cycle counts
`define SYS_CLK_HZ          100000000
`define RESTORE_DELAY_US    1500
`define BLANK_TIME_US       200
`define RESTORE_DELAY_CYC   (`RESTORE_DELAY_US * (`SYS_CLK_HZ / 1000000))
`define BLANK_TIME_CYC      (`BLANK_TIME_US * (`SYS_CLK_HZ / 1000000))

// duty ramp length in switching cycles
`define RAMP_CYCLES         15

// comparator-level widths
`define LEVEL_W             12
`define DUTY_W              8
`define DUTY_MAX            8'hFF

`endif

/* File: shared/phase_mgr_pkg.sv */
package phase_mgr_pkg;

    // pin level driven on each phase output
    typedef enum logic [1:0]
    {
        PH_LOW,
        PH_HIGH,
        PH_MID
    } phase_level_t;

    // light-load operating mode
    typedef enum logic [1:0]
    {
        LL_NORMAL,
        LL_DIODE_EMU,
        LL_PULSE_SKIP
    } light_mode_t;

endpackage

/* File: test/gate_driver_model.sv */
`timescale 1ns/10ps
`default_nettype none

// ----
// external gate drivers, one per phase
// ----
module gate_driver_model
    import phase_mgr_pkg::*;
(
    // phase command pins
    input  wire logic [1:0] phase_out [4],
    // switch states
    output logic [3:0]      low_on,
    output logic [3:0]      high_on
);
    // mid or unknown leaves both switches off, never risking shoot-through
    always_comb
    begin
        for (int i = 0; i < 4; i++)
        begin
            low_on[i]  = (phase_out[i] == PH_HIGH);
            high_on[i] = (phase_out[i] == PH_LOW);
        end
    end
endmodule

`default_nettype wire

/* File: test/phase_manager_assertions.sv */
`timescale 1ns/10ps
`default_nettype none

// ----
// phase manager port checker
// ----
module phase_manager_assertions
    import phase_mgr_pkg::*;
(
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst,
    // watched inputs
    input  wire logic        tri_select,
    input  wire logic        mode_at_rail,
    input  wire logic        cycle_start,
    // watched outputs
    input  wire logic [1:0]  phase_out [4],
    input  wire logic [3:0]  channel_active,
    input  wire logic [2:0]  phase_count,
    input  wire logic        latched_off,
    input  wire light_mode_t light_mode
);
    logic       no_high;
    logic       any_mid;
    logic [4:0] rail_cnt;

    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);

    // pin summaries
    // a disabled phase idles at mid or low, never high
    assign no_high = (phase_out[0] != PH_HIGH) && (phase_out[1] != PH_HIGH) &&
                     (phase_out[2] != PH_HIGH) && (phase_out[3] != PH_HIGH);
    assign any_mid = (phase_out[0] == PH_MID) || (phase_out[1] == PH_MID) ||
                     (phase_out[2] == PH_MID) || (phase_out[3] == PH_MID);

    // saturating run length of the rail level, long enough to cover sync and one decision
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            rail_cnt <= 5'h00;
        else
            rail_cnt <= !mode_at_rail ? 5'h00 : (rail_cnt == 5'h1F ? rail_cnt : rail_cnt + 5'h01);
    end

    sequence s_latched2;
        latched_off [*2];
    endsequence
    sequence s_two_level;
        !tri_select [*4];
    endsequence

    property p_latch_hold; latched_off |=> latched_off; endproperty
    property p_latch_quiet; s_latched2 |-> no_high; endproperty
    property p_floor; phase_count >= 3'h2 && phase_count <= 3'h4; endproperty
    property p_emu_two; $rose(light_mode == LL_DIODE_EMU) |-> phase_count == 3'h2; endproperty
    property p_rail; rail_cnt == 5'h1F |-> light_mode == LL_NORMAL; endproperty
    property p_step_down; phase_count < $past(phase_count) |-> phase_count == $past(phase_count) - 3'h1; endproperty
    property p_on_cycle; phase_count != $past(phase_count) |-> $past(cycle_start); endproperty
    // the active mask is registered from the count, so it trails the count by one edge
    property p_mask;
        channel_active != 4'h0 |->
            channel_active == ($past(phase_count) == 3'h4 ? 4'hF : ($past(phase_count) == 3'h3 ? 4'h7 : 4'h3));
    endproperty
    property p_two_level; s_two_level |-> !any_mid; endproperty
    property p_mid;
        (tri_select && !latched_off && channel_active[0] && !channel_active[3]) [*4] |-> phase_out[3] == PH_MID;
    endproperty

    a_latch_hold: assert property (p_latch_hold) else $error("latch-off released");
    a_latch_quiet: assert property (p_latch_quiet) else $error("phase driven while latched");
    a_floor: assert property (p_floor) else $error("phase count out of range");
    a_emu_two: assert property (p_emu_two) else $error("emulation entered off two phases");
    a_rail: assert property (p_rail) else $error("light-load mode at rail");
    a_step_down: assert property (p_step_down) else $error("drop of more than one phase");
    a_on_cycle: assert property (p_on_cycle) else $error("count changed off cycle boundary");
    a_mask: assert property (p_mask) else $error("active mask differs from count");
    a_two_level: assert property (p_two_level) else $error("mid level with two-level select");
    a_mid: assert property (p_mid) else $error("dropped phase not at mid");
endmodule

bind phase_manager phase_manager_assertions chk_u (.sys_clk, .rst, .tri_select, .mode_at_rail, .cycle_start,
    .phase_out, .channel_active, .phase_count, .latched_off, .light_mode);

`default_nettype wire

/* File: test/tb_multiphase_light_load_phase_manager.sv */
`timescale 1ns/10ps
`default_nettype none

// ----
// phase manager bench
// ----
module tb_multiphase_light_load_phase_manager
    import phase_mgr_pkg::*;
;
    logic        sys_clk, rst, third_phase_strap, fourth_phase_strap, tri_select, mode_at_rail;
    logic        mode_below_disable, total_below_75, total_below_50, total_above_hyst, light_load_low;
    logic        deep_light_load, cycle_start, latched_off;
    logic [3:0]  peak_trip, two_thirds_trip, zero_current, channel_active, low_on, high_on;
    logic [7:0]  steady_duty, ramp;
    logic [1:0]  phase_out [4];
    logic [2:0]  phase_count;
    light_mode_t light_mode;
    int          fails, total_checks, ticks, n;

    // restore hold shortened so the wait stays longer than one full drop ramp
    phase_manager #(.RESTORE_CYC(400), .BLANK_CYC(20)) dut_u (.sys_clk, .rst, .third_phase_strap,
        .fourth_phase_strap, .tri_select, .mode_at_rail, .mode_below_disable, .total_below_75,
        .total_below_50, .total_above_hyst, .light_load_low, .deep_light_load, .peak_trip,
        .two_thirds_trip, .zero_current, .steady_duty, .ramp, .cycle_start, .phase_out,
        .channel_active, .phase_count, .latched_off, .light_mode);
    gate_driver_model drv_u (.phase_out, .low_on, .high_on);

    // clock
    initial
    begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // switching cycle every 16 clocks, ramp and hang limit
    always @(posedge sys_clk)
    begin
        #1;
        ticks++;
        ramp = {ticks[3:0], 4'h0};
        cycle_start = (ticks[3:0] == 4'h0);
        if (ticks > 20000)
        begin
            fails++;
            test_done();
        end
    end

    task chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task wcs(input int k);
        repeat (k)
        begin
            @(posedge sys_clk);
            while (cycle_start !== 1'b1) @(posedge sys_clk);
        end
        #1;
    endtask

    // counts switching cycles until the expected count shows
    task upto(input logic [2:0] exp, input int lim);
        n = 0;
        while (phase_count !== exp && n < lim)
        begin
            wcs(1);
            n++;
        end
    endtask

    task test_done();
        if (fails == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // the count comes up at two and is added back one phase per cycle
    task t_start();
        chk(phase_count, 3'h2);
        total_above_hyst = 1'b1;
        upto(3'h4, 4);
        total_above_hyst = 1'b0;
        wcs(1);
        chk(phase_count, 3'h4);
        chk(channel_active, 4'hF);
    endtask

    // both disabling levels, two-level drive meanwhile
    task t_rail();
        {total_below_75, total_below_50, light_load_low, tri_select} = 4'hE;
        for (int i = 0; i < 2; i++)
        begin
            {mode_at_rail, mode_below_disable} = {i[0], i[0]};
            wcs(20);
            chk(phase_count, 3'h4);
            chk(light_mode, LL_NORMAL);
        end
        {mode_at_rail, mode_below_disable, total_below_75, total_below_50, light_load_low, tri_select} = 6'h11;
        wcs(2);
    endtask

    task t_drop();
        total_below_75 = 1'b1;
        upto(3'h3, 20);
        chk(n >= 16 && n <= 17, 1'b1);
        repeat (2) @(posedge sys_clk);
        #1;
        chk(channel_active, 4'h7);
        chk(phase_out[3], PH_MID);
        chk(low_on[3] | high_on[3], 1'b0);
        total_below_50 = 1'b1;
        upto(3'h2, 20);
        chk(phase_count, 3'h2);
    endtask

    task t_light();
        light_load_low = 1'b1;
        wcs(3);
        chk(light_mode, LL_DIODE_EMU);
        zero_current = 4'h1;
        n = 0;
        repeat (32)
        begin
            @(posedge sys_clk);
            #1;
            if (phase_out[0] === PH_MID)
                n = 1;
        end
        chk(n, 1);
        deep_light_load = 1'b1;
        wcs(3);
        chk(light_mode, LL_PULSE_SKIP);
        {light_load_low, deep_light_load, zero_current, total_below_75, total_below_50} = 8'h00;
    endtask

    task t_add();
        total_above_hyst = 1'b1;
        upto(3'h3, 4);
        chk(phase_count, 3'h3);
        peak_trip = 4'h1;
        repeat (3) @(posedge sys_clk);
        #1;
        peak_trip = 4'h0;
        wcs(1);
        chk(phase_count, 3'h4);
        chk(latched_off, 1'b0);
        total_above_hyst = 1'b0;
    endtask

    task t_fast();
        total_below_75 = 1'b1;
        upto(3'h3, 20);
        two_thirds_trip = 4'h1;
        wcs(2);
        chk(phase_count, 3'h4);
        two_thirds_trip = 4'h0;
        wcs(20);
        chk(phase_count, 3'h4);
        upto(3'h3, 30);
        chk(phase_count, 3'h3);
    endtask

    task t_peak();
        peak_trip = 4'h2;
        repeat (6) @(posedge sys_clk);
        #1;
        chk(latched_off, 1'b1);
        chk({phase_out[0], phase_out[1], phase_out[2], phase_out[3]}, 8'hAA);
        chk({low_on, high_on}, 8'h00);
    endtask

    // reset, then the scenarios in turn; the latching one goes last
    initial
    begin
        {rst, third_phase_strap, fourth_phase_strap, tri_select, mode_at_rail, mode_below_disable} = 6'h3D;
        {total_below_75, total_below_50, total_above_hyst, light_load_low, deep_light_load} = 5'h00;
        {peak_trip, two_thirds_trip, zero_current} = 12'h000;
        steady_duty = 8'h80;
        repeat (20) @(posedge sys_clk);
        #1;
        rst = 1'b0;
        t_start();
        t_rail();
        t_drop();
        t_light();
        t_add();
        t_fast();
        t_peak();
        test_done();
    end
endmodule

`default_nettype wire
